/* rtl/rmiip3_port.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rmiip3_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (WIDTH < 1 || DEPTH < 2) begin : g_bad
    $error("fifo needs width >= 1 and depth >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : rmiip3_fifo

////////////////////////////////////////////////////////////////////////////////
module rmiip3_port
  import rmiip3_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  // link side
  input wire logic port3_ref_clock_in,
  output logic port3_ref_clock_out,
  output logic port3_ref_clock_out_oe,
  output logic port3_rx_valid_out,
  output logic port3_rx_data_bit1_out,
  output logic port3_rx_data_bit0_out,
  input wire logic port3_tx_enable_in,
  input wire logic port3_tx_data_bit1_in,
  input wire logic port3_tx_data_bit0_in,
  input wire logic [UPPER_W-1:0] port3_tx_data_upper_in,
  input wire logic port3_error_in,
  // configuration
  input wire logic ref_clock_internal,
  input wire logic ref_clock_invert,
  input wire logic half_duplex,
  // egress stream toward the link
  input wire logic egress_valid,
  output logic egress_ready,
  input wire logic [DIBIT_W-1:0] egress_data,
  // ingress stream from the link
  output logic ingress_valid,
  output logic [DIBIT_W-1:0] ingress_data,
  output logic ingress_end,
  output logic ingress_bad,
  output logic collision
);
  // two-flop synchronisers for everything arriving from the pins
  localparam int SYNC_W = 5 + UPPER_W;
  logic [SYNC_W-1:0] sync1, sync2;
  logic ref_s, en_s, err_s, upper_bad_s;
  logic [DIBIT_W-1:0] txd_s;
  logic int_ref, ref_prev, ref_sel, edge_en;
  logic fifo_valid;
  logic [DIBIT_W-1:0] fifo_data;
  rmiip3_rx_state_e state, next_state;
  logic err_seen, next_err_seen;
  logic next_rx_valid;
  logic [DIBIT_W-1:0] rx_data, next_rx_data;
  logic next_in_valid, next_in_end, next_in_bad;
  logic [DIBIT_W-1:0] next_in_data;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {port3_tx_data_upper_in, port3_error_in, port3_tx_enable_in,
                port3_tx_data_bit1_in, port3_tx_data_bit0_in, port3_ref_clock_in};
      sync2 <= sync1;
    end
  end
  assign ref_s = sync2[0];
  assign txd_s = sync2[2:1];
  assign en_s = sync2[3];
  // an unconnected upper data pin or error pin must sit low or every frame ends flagged bad
  assign upper_bad_s = |sync2[SYNC_W-1:5];
  assign err_s = sync2[4] | upper_bad_s;

  ////////////////////////////////////////////////////////////////////////////////
  // reference selection: internal toggle at 50 MHz or the sampled pin
  assign ref_sel = ref_clock_internal ? int_ref : ref_s;
  assign edge_en = ref_sel && !ref_prev;
  assign port3_ref_clock_out = ref_clock_internal && (int_ref ^ ref_clock_invert);
  assign port3_ref_clock_out_oe = ref_clock_internal;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      int_ref <= RESET_LEVEL;
      ref_prev <= RESET_LEVEL;
    end else begin
      int_ref <= ~int_ref;
      ref_prev <= ref_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // egress: one dibit per reference edge; an empty fifo ends the frame,
  // so the source must keep up once a frame has started
  rmiip3_fifo #(.WIDTH(DIBIT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(egress_valid),
    .in_ready(egress_ready),
    .in_data(egress_data),
    .out_valid(fifo_valid),
    .out_ready(edge_en),
    .out_data(fifo_data)
  );

  always_comb begin
    next_rx_valid = port3_rx_valid_out;
    next_rx_data = rx_data;
    if (edge_en) begin
      next_rx_valid = fifo_valid;
      next_rx_data = fifo_valid ? fifo_data : '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port3_rx_valid_out <= 1'b0;
      rx_data <= '0;
    end else begin
      port3_rx_valid_out <= next_rx_valid;
      rx_data <= next_rx_data;
    end
  end
  assign port3_rx_data_bit1_out = rx_data[1];
  assign port3_rx_data_bit0_out = rx_data[0];

  // collision per the reduced interface: both directions active at once in half duplex
  assign collision = half_duplex && en_s && port3_rx_valid_out;

  ////////////////////////////////////////////////////////////////////////////////
  // ingress: dibits forwarded as sampled; the end pulse carries the verdict
  // since the fifo-less path cannot retract dibits already passed on
  always_comb begin
    next_state = state;
    next_err_seen = err_seen;
    next_in_valid = 1'b0;
    next_in_data = ingress_data;
    next_in_end = 1'b0;
    next_in_bad = 1'b0;
    if (edge_en) begin
      unique case (state)
        RMIIP3_IDLE: begin
          if (en_s) begin
            next_state = RMIIP3_FRAME;
            next_err_seen = err_s;
            next_in_valid = 1'b1;
            next_in_data = txd_s;
          end
        end
        RMIIP3_FRAME: begin
          if (en_s) begin
            next_err_seen = err_seen | err_s;
            next_in_valid = 1'b1;
            next_in_data = txd_s;
          end else begin
            next_state = RMIIP3_IDLE;
            next_in_end = 1'b1;
            next_in_bad = err_seen;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= RMIIP3_IDLE;
      err_seen <= 1'b0;
      ingress_valid <= 1'b0;
      ingress_data <= '0;
      ingress_end <= 1'b0;
      ingress_bad <= 1'b0;
    end else begin
      state <= next_state;
      err_seen <= next_err_seen;
      ingress_valid <= next_in_valid;
      ingress_data <= next_in_data;
      ingress_end <= next_in_end;
      ingress_bad <= next_in_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_hold_between_edges;
    @(posedge clk_sys) disable iff (!resetn)
      !edge_en |=> $stable(port3_rx_valid_out) && $stable(rx_data);
  endproperty
  a_hold_between_edges: assert property (p_hold_between_edges)
    else $error("link outputs changed without a reference edge");
  property p_send_on_edge;
    @(posedge clk_sys) disable iff (!resetn)
      edge_en && fifo_valid |=> port3_rx_valid_out && rx_data == $past(fifo_data);
  endproperty
  a_send_on_edge: assert property (p_send_on_edge)
    else $error("queued dibit not sent on reference edge");
  property p_idle_when_empty;
    @(posedge clk_sys) disable iff (!resetn)
      edge_en && !fifo_valid |=> !port3_rx_valid_out;
  endproperty
  a_idle_when_empty: assert property (p_idle_when_empty)
    else $error("carrier held with nothing queued");
  property p_collision;
    @(posedge clk_sys) disable iff (!resetn)
      $past(resetn) && $past(resetn, 2) && half_duplex && port3_rx_valid_out
        |-> collision == $past(port3_tx_enable_in, 2);
  endproperty
  a_collision: assert property (p_collision)
    else $error("collision does not follow transmit enable overlap in half duplex");
  property p_bad_frame;
    @(posedge clk_sys) disable iff (!resetn)
      edge_en && en_s && err_s ##1 (!ingress_end)[*1] |-> err_seen;
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("error during frame not remembered");
  property p_end_verdict;
    @(posedge clk_sys) disable iff (!resetn)
      edge_en && state == RMIIP3_FRAME && !en_s |=> ingress_end && ingress_bad == $past(err_seen);
  endproperty
  a_end_verdict: assert property (p_end_verdict)
    else $error("frame end or discard verdict wrong");
  property p_ext_ref_quiet;
    @(posedge clk_sys) disable iff (!resetn)
      !ref_clock_internal |-> !port3_ref_clock_out_oe && !port3_ref_clock_out;
  endproperty
  a_ext_ref_quiet: assert property (p_ext_ref_quiet)
    else $error("reference driven while external source chosen");
  property p_int_ref_toggles;
    @(posedge clk_sys) disable iff (!resetn)
      ref_clock_internal && $stable(ref_clock_internal) && $stable(ref_clock_invert)
        && $past(resetn) |-> port3_ref_clock_out != $past(port3_ref_clock_out);
  endproperty
  a_int_ref_toggles: assert property (p_int_ref_toggles)
    else $error("internal reference not running at half the system rate");
endmodule : rmiip3_port
`default_nettype wire

/* rtl/rmiip3_pkg.sv */
package rmiip3_pkg;
  localparam int CLK_SYS_PERIOD_NS = 10;
  localparam int REF_CLK_PERIOD_NS = 20;
  // cycles of clk_sys per half period of the internal 50 MHz reference
  localparam int REF_HALF_CYCLES = REF_CLK_PERIOD_NS / (2 * CLK_SYS_PERIOD_NS);
  localparam int DIBIT_W = 2;
  localparam int UPPER_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic RESET_LEVEL = 1'b0;
  typedef enum logic {RMIIP3_IDLE, RMIIP3_FRAME} rmiip3_rx_state_e;
endpackage : rmiip3_pkg

/* bench/rmiip3_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module rmiip3_far_end (
  input wire logic hold,
  input wire logic go,
  input wire logic [31:0] fr,
  input wire logic [4:0] len,
  input wire logic [4:0] err_at,
  input wire logic [1:0] up,
  input wire logic rx_valid,
  input wire logic [1:0] rxd,
  output logic ref_clk,
  output logic tx_en,
  output logic [1:0] txd,
  output logic err,
  output logic [1:0] upper,
  output logic busy
);
  logic [1:0] got [$];
  int i;
  initial begin
    ref_clk = 1'b0;
    tx_en = 1'b0;
    txd = 2'h0;
    err = 1'b0;
    upper = 2'h0;
    busy = 1'b0;
  end
  // a stall parks the reference low so nothing pops
  always #40 if (!hold || ref_clk) ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rx_valid === 1'b1) got.push_back(rxd);
  // launch on the falling edge so pins are settled well before the rise
  always @(negedge ref_clk) begin
    if (go && !busy) begin
      busy = 1'b1;
      i = 0;
    end
    if (busy && i < len) begin
      tx_en <= 1'b1;
      txd <= fr[2*i +: 2];
      err <= (i == err_at && up == 2'h0);
      upper <= (i == err_at) ? up : 2'h0;
      i++;
    end else begin
      tx_en <= 1'b0;
      busy = 1'b0;
      txd <= ~txd; // idle data flips so no stale value can pass
      err <= 1'b0;
      upper <= 2'h0;
    end
  end
endmodule : rmiip3_far_end
`default_nettype wire

/* bench/rmiip3_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module rmiip3_port_tb_top;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ref_int = 1'b0;
  logic ref_inv = 1'b0;
  logic hd = 1'b0;
  logic ev = 1'b0;
  logic [1:0] ed = 2'h0;
  logic hold = 1'b0;
  logic go = 1'b0;
  logic [31:0] fr;
  logic [4:0] len = 5'h6;
  logic [4:0] ea = 5'h1f;
  logic [1:0] up = 2'h0;
  logic [1:0] rq [$];
  logic g_end = 1'b0;
  logic g_bad = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  wire ref_clk, tx_en, err, rdy, iv, ie, ib, col, rv, r1, r0, co, coe, busy;
  wire [1:0] txd, upper, id;
  rmiip3_port u_dut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .port3_ref_clock_in(ref_clk),
    .port3_ref_clock_out(co),
    .port3_ref_clock_out_oe(coe),
    .port3_rx_valid_out(rv),
    .port3_rx_data_bit1_out(r1),
    .port3_rx_data_bit0_out(r0),
    .port3_tx_enable_in(tx_en),
    .port3_tx_data_bit1_in(txd[1]),
    .port3_tx_data_bit0_in(txd[0]),
    .port3_tx_data_upper_in(upper),
    .port3_error_in(err),
    .ref_clock_internal(ref_int),
    .ref_clock_invert(ref_inv),
    .half_duplex(hd),
    .egress_valid(ev),
    .egress_ready(rdy),
    .egress_data(ed),
    .ingress_valid(iv),
    .ingress_data(id),
    .ingress_end(ie),
    .ingress_bad(ib),
    .collision(col)
  );
  rmiip3_far_end u_far (
    .hold(hold),
    .go(go),
    .fr(fr),
    .len(len),
    .err_at(ea),
    .up(up),
    .rx_valid(rv),
    .rxd({r1, r0}),
    .ref_clk(ref_clk),
    .tx_en(tx_en),
    .txd(txd),
    .err(err),
    .upper(upper),
    .busy(busy)
  );
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (iv === 1'b1) rq.push_back(id);
    if (ie === 1'b1) begin
      g_end <= 1'b1;
      g_bad <= ib;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic burst(input int n);
    for (int k = 0; k < n; k++) begin
      ed <= k[1:0] ^ 2'h1;
      ev <= 1'b1;
      do @(negedge clk_sys); while (rdy !== 1'b1);
      @(posedge clk_sys);
    end
    ev <= 1'b0;
  endtask : burst
  // go is held past one reference period so the far end cannot miss it
  task automatic send(input logic [4:0] at, input logic [1:0] u);
    int n;
    rq.delete();
    ea <= at;
    up <= u;
    g_end <= 1'b0;
    go <= 1'b1;
    cyc(12);
    go <= 1'b0;
    n = 0;
    while (g_end !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
  endtask : send
  ////////////////////////////////////////
  task automatic t_clk;
    logic v;
    @(negedge clk_sys);
    chk(coe === 1'b0 && co === 1'b0, "ref out idle");
    @(posedge clk_sys);
    ref_int <= 1'b1;
    cyc(3);
    @(negedge clk_sys);
    v = co;
    chk(coe === 1'b1, "ref out enable");
    @(negedge clk_sys);
    chk(co === ~v, "ref out toggle");
    v = co;
    @(posedge clk_sys);
    ref_inv <= 1'b1;
    @(negedge clk_sys);
    chk(co === v, "ref out invert");
    @(posedge clk_sys);
    ref_int <= 1'b0;
    ref_inv <= 1'b0;
    cyc(4);
  endtask : t_clk
  task automatic t_fill;
    hold <= 1'b1;
    cyc(10);
    u_far.got.delete();
    burst(8);
    cyc(1);
    ev <= 1'b1;
    repeat (3) @(negedge clk_sys) chk(rdy === 1'b0, "full not refused");
    @(posedge clk_sys);
    ev <= 1'b0;
    hold <= 1'b0;
    cyc(120);
    chk(u_far.got.size() == 8, "egress count");
    foreach (u_far.got[k]) chk(u_far.got[k] === (k[1:0] ^ 2'h1), "egress dibit");
    chk(rv === 1'b0 && r1 === 1'b0 && r0 === 1'b0, "egress end");
  endtask : t_fill
  task automatic t_rx(input logic [4:0] at, input logic [1:0] u, input logic bad);
    send(at, u);
    chk(g_end === 1'b1 && rq.size() == 6, "rx count");
    foreach (rq[k]) chk(rq[k] === fr[2*k +: 2], "rx dibit");
    chk(g_bad === bad, "rx discard flag");
  endtask : t_rx
  task automatic t_col(input logic h);
    hd <= h;
    len <= 5'h10;
    fork
      send(5'h1f, 2'h0);
      begin
        cyc(14);
        burst(6);
        cyc(10);
        @(negedge clk_sys);
        chk(rv === 1'b1 && col === h, "collision");
      end
    join
    len <= 5'h6;
    cyc(40);
  endtask : t_col
  ////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    for (int k = 0; k < 16; k++) fr[2*k +: 2] = k[1:0] ^ 2'h2;
    cyc(6);
    resetn <= 1'b1;
    cyc(2);
    t_clk;
    t_fill;
    t_rx(5'h1f, 2'h0, 1'b0);
    t_rx(5'h2, 2'h0, 1'b1);
    t_rx(5'h2, 2'h2, 1'b1);
    t_rx(5'h1f, 2'h0, 1'b0);
    t_col(1'b0);
    t_col(1'b1);
    close_out;
  end
  initial begin
    #200000;
    err_total++;
    close_out;
  end
endmodule : rmiip3_port_tb_top
`default_nettype wire
